// ==== rtl/e1_ldm_params.svh ====
`ifndef E1_LDM_PARAMS_SVH
`define E1_LDM_PARAMS_SVH

// Register offsets
`define LDM_CFG_ADDR      4'h0
`define LDM_ERR_ADDR      4'h1
`define LDM_LOS_ADDR      4'h2
`define LDM_STAT_ADDR     4'h3
`define LDM_FLAG0_ADDR    4'h4
`define LDM_MASK0_ADDR    4'h5
`define LDM_EDGE_ADDR     4'h6
`define LDM_FLAG2_ADDR    4'h7
`define LDM_MASK2_ADDR    4'h8

// Field positions
`define LDM_HDB3_BIT      0
`define LDM_RXFMT_LSB     1
`define LDM_TXFMT_LSB     3
`define LDM_E1ON_BIT      5
`define LDM_HOLDSEL_BIT   7
`define LDM_INS_BIT       6
`define LDM_STD_BIT       7
`define LDM_THR_LSB       4
`define LDM_CRIT_BIT      7
`define LDM_EDGE_BIT      1
`define LDM_FLAG2_LSB     2

// Reset values
`define LDM_CFG_RST       8'h00
`define LDM_MASK_RST      4'h0

// Counts in bit intervals, marks and channels
`define LDM_AMI_ZERO_LIM  5'h0F
`define LDM_HDB3_ZERO_LIM 5'h03
`define LDM_CLR_ZERO_RUN  5'h10
`define LDM_N_SHORT       32
`define LDM_N_LONG        2048
`define LDM_M_WIN         32
`define LDM_MIN_MARKS     4
`define LDM_CHANNELS      22

`endif

// ==== rtl/e1_ldm_pkg.sv ====
`default_nettype none
package e1_ldm_pkg;

    typedef enum logic [1:0] {
        RX_SINGLE_NRZ, RX_DUAL_NRZ, RX_DUAL_RZ, RX_SLICED
    } rx_fmt_t;

    typedef enum logic [1:0] {
        TX_SINGLE_NRZ, TX_DUAL_NRZ, TX_DUAL_RZ, TX_SPARE
    } tx_fmt_t;

    typedef struct packed {
        logic [6:0]       sync1;
        logic [6:0]       sync2;
        logic [2:0]       clk_d;
        logic             hdb3;
        rx_fmt_t          rx_fmt;
        tx_fmt_t          tx_fmt;
        logic             e1_on;
        logic             hold_sel;
        logic             ins;
        logic             std;
        logic [2:0]       thr;
        logic             crit;
        logic             edge_sel;
        logic [1:0]       mask0;
        logic [1:0]       flag0;
        logic [3:0]       mask2;
        logic [3:0]       flag2;
        logic [7:0]       rdata;
        logic [1:0]       last_pol;
        logic [1:0]       bpv_pol;
        logic [1:0]       bpv_seen;
        logic [1:0][4:0]  zcnt;
        logic [1:0]       absent;
        logic [1:0][11:0] acnt;
        logic [1:0]       win;
        logic [1:0][5:0]  wcnt;
        logic [1:0][5:0]  mcnt;
        logic [4:0]       slot;
        logic             marker;
        logic             ser;
        logic             e1_clk;
        logic             rxd_pos;
        logic             rxd_neg;
        logic             rxd_out;
        logic             rx_clk;
        logic             txo_pol;
        logic             txl_pos;
        logic             txl_neg;
    } state_t;

endpackage : e1_ldm_pkg
`default_nettype wire

// ==== rtl/e1_line_defect_monitor.sv ====
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "e1_ldm_params.svh"

module e1_line_defect_monitor #(
    parameter int ABS_SHORT = `LDM_N_SHORT,
    parameter int ABS_LONG  = `LDM_N_LONG,
    parameter int WIN_LEN   = `LDM_M_WIN
) (
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_ce,
    // Register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // Receive line pins
    input  wire logic        i_rx_clk,
    input  wire logic        i_rx_pos,
    input  wire logic        i_rx_neg,
    // Front end amplitude flags
    input  wire logic        i_amp_below,
    input  wire logic        i_amp_above,
    output logic      [2:0]  o_amplitude_threshold,
    // Transmit system pins
    input  wire logic        i_tx_clk,
    input  wire logic        i_tx_pos,
    input  wire logic        i_tx_neg,
    output logic             o_tx_line_pos,
    output logic             o_tx_line_neg,
    // Reference clock and other channels
    input  wire logic        i_ref_clock_2m,
    input  wire logic [21:1] i_other_line_absence,
    // Alternate receive source
    input  wire logic        i_alt_active,
    input  wire logic        i_alt_data_pos,
    input  wire logic        i_alt_data_neg,
    input  wire logic        i_alt_clock,
    // Receive system outputs
    output logic             o_rx_data_out,
    output logic             o_rx_data_pos,
    output logic             o_rx_data_neg,
    output logic             o_rx_clock_out,
    // Serial absence indication
    output logic             o_free_run_e1_clock,
    output logic             o_serial_frame_marker,
    output logic             o_serial_frame_marker_oe_n,
    output logic             o_serial_absence_out,
    output logic             o_serial_absence_out_oe_n,
    // Status and interrupt
    output logic             o_line_absence_state,
    output logic             o_sys_absence_state,
    output logic             o_int_n
);

    //--------------------------------------------------------------
    // Local indices and state
    //--------------------------------------------------------------
    localparam int S_RXC = 0;
    localparam int S_RXP = 1;
    localparam int S_RXN = 2;
    localparam int S_TXC = 3;
    localparam int S_TXP = 4;
    localparam int S_TXN = 5;
    localparam int S_REF = 6;
    localparam logic [4:0] LAST_SLOT = 5'(`LDM_CHANNELS - 1);

    e1_ldm_pkg::state_t st_r;
    e1_ldm_pkg::state_t st_nxt;

    logic [1:0] tick;
    logic [1:0] mark;
    logic [1:0] pol;
    logic [1:0] evt_v;
    logic [1:0] evt_z;
    logic [1:0] below;
    logic [1:0] start_ok;
    logic [1:0] chg;
    logic       ref_tick;
    logic       tx_single;
    logic [4:0] zlim;
    logic [11:0] n_lim;
    logic [5:0] mc;
    logic       wsel;
    logic       rsel;
    logic [`LDM_CHANNELS-1:0] all_abs;

    //--------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // Two-stage capture of pin inputs
        st_nxt.sync1 = {i_ref_clock_2m, i_tx_neg, i_tx_pos, i_tx_clk,
                        i_rx_neg, i_rx_pos, i_rx_clk};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.clk_d = {st_r.sync2[S_REF], st_r.sync2[S_TXC],
                        st_r.sync2[S_RXC]};
        tick[0]  = st_r.sync2[S_RXC] & ~st_r.clk_d[0];
        tick[1]  = st_r.sync2[S_TXC] & ~st_r.clk_d[1];
        ref_tick = st_r.sync2[S_REF] & ~st_r.clk_d[2];
        tx_single = (st_r.tx_fmt == e1_ldm_pkg::TX_SINGLE_NRZ);
        mark[0] = st_r.sync2[S_RXP] | st_r.sync2[S_RXN];
        mark[1] = tx_single ? st_r.sync2[S_TXP]
                            : (st_r.sync2[S_TXP] | st_r.sync2[S_TXN]);
        pol[0]  = st_r.sync2[S_RXN];
        pol[1]  = st_r.sync2[S_TXN];
        evt_v   = 2'h0;
        evt_z   = 2'h0;
        chg     = 2'h0;
        mc      = 6'h00;
        n_lim   = st_r.crit ? 12'(ABS_LONG) : 12'(ABS_SHORT);
        below[0]    = i_amp_below;
        below[1]    = ~mark[1];
        start_ok[0] = mark[0] & i_amp_above;
        start_ok[1] = mark[1];

        // Violation and zero-run monitors per path
        // both paths monitored
        for (int p = 0; p < 2; p++)
        begin
            zlim = (st_r.hdb3 && !(p == 1 && tx_single))
                 ? `LDM_HDB3_ZERO_LIM : `LDM_AMI_ZERO_LIM;
            if (tick[p])
            begin
                if (mark[p])
                begin
                    st_nxt.zcnt[p] = 5'h00;
                    // no violation check in single rail
                    if (!(p == 1 && tx_single))
                    begin
                        if (pol[p] == st_r.last_pol[p])
                        begin
                            if (st_r.hdb3)
                            begin
                                evt_v[p] = st_r.bpv_seen[p] &
                                    (pol[p] == st_r.bpv_pol[p]);
                                st_nxt.bpv_pol[p]  = pol[p];
                                st_nxt.bpv_seen[p] = 1'b1;
                            end
                            else
                            begin
                                evt_v[p] = 1'b1;
                            end
                        end
                        st_nxt.last_pol[p] = pol[p];
                    end
                end
                else
                begin
                    evt_z[p] = (st_r.zcnt[p] == zlim);
                    if (st_r.zcnt[p] != `LDM_CLR_ZERO_RUN)
                        st_nxt.zcnt[p] = st_r.zcnt[p] + 5'h01;
                end
            end
        end

        // Line and system absence detectors
        for (int p = 0; p < 2; p++)
        begin
            // system detector only in dual rail
            if (p == 1 && tx_single)
            begin
                st_nxt.absent[p] = 1'b0;
                st_nxt.acnt[p]   = 12'h000;
                st_nxt.win[p]    = 1'b0;
            end
            else if (tick[p] && !st_r.absent[p])
            begin
                if (below[p])
                begin
                    st_nxt.acnt[p] = st_r.acnt[p] + 12'h001;
                    if (st_r.acnt[p] + 12'h001 >= n_lim)
                    begin
                        st_nxt.absent[p] = 1'b1;
                        st_nxt.acnt[p]   = 12'h000;
                        st_nxt.win[p]    = 1'b0;
                    end
                end
                else
                begin
                    st_nxt.acnt[p] = 12'h000;
                end
            end
            else if (tick[p])
            begin
                // clearing window opens on a mark
                if (!st_r.win[p])
                begin
                    if (start_ok[p])
                    begin
                        st_nxt.win[p]  = 1'b1;
                        st_nxt.wcnt[p] = 6'h01;
                        st_nxt.mcnt[p] = 6'h01;
                    end
                end
                else
                begin
                    mc = st_r.mcnt[p] + {5'h00, mark[p]};
                    st_nxt.wcnt[p] = st_r.wcnt[p] + 6'h01;
                    st_nxt.mcnt[p] = mc;
                    if ((p == 0 && mark[p] && !i_amp_above) ||
                        st_nxt.zcnt[p] == `LDM_CLR_ZERO_RUN)
                    begin
                        st_nxt.win[p] = 1'b0;
                    end
                    else if (st_r.wcnt[p] + 6'h01 == 6'(WIN_LEN))
                    begin
                        st_nxt.win[p] = 1'b0;
                        if (mc >= 6'(`LDM_MIN_MARKS))
                            st_nxt.absent[p] = 1'b0;
                    end
                end
            end
        end

        for (int p = 0; p < 2; p++)
        begin
            chg[p] = st_nxt.absent[p] & (st_r.edge_sel | ~st_r.absent[p]);
            if (st_r.edge_sel)
                chg[p] = st_nxt.absent[p] ^ st_r.absent[p];
        end

        // Register writes, flag clears lose to new events
        wsel = i_wr;
        rsel = i_rd;
        if (wsel)
        begin
            case (i_addr)
                `LDM_CFG_ADDR:
                begin
                    st_nxt.hdb3     = i_wdata[`LDM_HDB3_BIT];
                    st_nxt.rx_fmt   = e1_ldm_pkg::rx_fmt_t'(
                        i_wdata[`LDM_RXFMT_LSB +: 2]);
                    st_nxt.tx_fmt   = e1_ldm_pkg::tx_fmt_t'(
                        i_wdata[`LDM_TXFMT_LSB +: 2]);
                    st_nxt.e1_on    = i_wdata[`LDM_E1ON_BIT];
                    st_nxt.hold_sel = i_wdata[`LDM_HOLDSEL_BIT];
                end
                `LDM_ERR_ADDR:
                begin
                    st_nxt.std = i_wdata[`LDM_STD_BIT];
                end
                `LDM_LOS_ADDR:
                begin
                    st_nxt.thr  = i_wdata[`LDM_THR_LSB +: 3];
                    st_nxt.crit = i_wdata[`LDM_CRIT_BIT];
                end
                `LDM_FLAG0_ADDR: st_nxt.flag0 = st_r.flag0 & ~i_wdata[1:0];
                `LDM_MASK0_ADDR: st_nxt.mask0 = i_wdata[1:0];
                `LDM_EDGE_ADDR:  st_nxt.edge_sel = i_wdata[`LDM_EDGE_BIT];
                `LDM_FLAG2_ADDR: st_nxt.flag2 = st_r.flag2 &
                                     ~i_wdata[`LDM_FLAG2_LSB +: 4];
                `LDM_MASK2_ADDR: st_nxt.mask2 = i_wdata[`LDM_FLAG2_LSB +: 4];
                default: ;
            endcase
        end
        st_nxt.flag0 = st_nxt.flag0 | chg;
        st_nxt.flag2 = st_nxt.flag2 | {evt_v[1], evt_v[0],
                                       evt_z[1], evt_z[0]};

        if (tick[1])
        begin
            st_nxt.txl_pos = st_r.sync2[S_TXP];
            st_nxt.txl_neg = 1'b0;
            if (!tx_single && mark[1])
            begin
                st_nxt.txo_pol = st_r.ins ? st_r.txo_pol : pol[1];
                st_nxt.txl_pos = ~st_nxt.txo_pol;
                st_nxt.txl_neg = st_nxt.txo_pol;
                st_nxt.ins     = 1'b0;
            end
            else if (!tx_single)
            begin
                st_nxt.txl_pos = 1'b0;
            end
        end
        if (wsel && i_addr == `LDM_ERR_ADDR && i_wdata[`LDM_INS_BIT])
            st_nxt.ins = 1'b1;

        // Read data stands one cycle only
        st_nxt.rdata = 8'h00;
        if (rsel)
        begin
            case (i_addr)
                `LDM_CFG_ADDR:   st_nxt.rdata = {st_r.hold_sel, 1'b0,
                                     st_r.e1_on, st_r.tx_fmt, st_r.rx_fmt,
                                     st_r.hdb3};
                `LDM_ERR_ADDR:   st_nxt.rdata = {st_r.std, st_r.ins, 6'h00};
                `LDM_LOS_ADDR:   st_nxt.rdata = {st_r.crit, st_r.thr, 4'h0};
                `LDM_STAT_ADDR:  st_nxt.rdata = {6'h00, st_r.absent};
                `LDM_FLAG0_ADDR: st_nxt.rdata = {6'h00, st_r.flag0};
                `LDM_MASK0_ADDR: st_nxt.rdata = {6'h00, st_r.mask0};
                `LDM_EDGE_ADDR:  st_nxt.rdata = {6'h00, st_r.edge_sel, 1'b0};
                `LDM_FLAG2_ADDR: st_nxt.rdata = {2'h0, st_r.flag2, 2'h0};
                `LDM_MASK2_ADDR: st_nxt.rdata = {2'h0, st_r.mask2, 2'h0};
                default:         st_nxt.rdata = 8'h00;
            endcase
        end

        // serial stream on reference rising edge
        all_abs = {i_other_line_absence, st_r.absent[0]};
        st_nxt.e1_clk = st_r.e1_on & st_r.sync2[S_REF];
        if (ref_tick)
        begin
            st_nxt.slot   = (st_r.slot == LAST_SLOT) ? 5'h00
                                                     : st_r.slot + 5'h01;
            st_nxt.marker = (st_nxt.slot == 5'h00);
            st_nxt.ser    = all_abs[st_nxt.slot];
        end

        if (i_alt_active)
        begin
            st_nxt.rxd_pos = i_alt_data_pos;
            st_nxt.rxd_neg = i_alt_data_neg;
            st_nxt.rxd_out = i_alt_data_pos;
            st_nxt.rx_clk  = i_alt_clock;
        end
        // absence drives data out low, pos/neg low unless sliced; clock high, or reference when hold_sel
        else if (st_r.absent[0])
        begin
            st_nxt.rx_clk  = st_r.hold_sel ? st_r.sync2[S_REF] : 1'b1;
            st_nxt.rxd_out = 1'b0;
            st_nxt.rxd_pos = (st_r.rx_fmt == e1_ldm_pkg::RX_SLICED)
                           ? st_r.sync2[S_RXP] : 1'b0;
            st_nxt.rxd_neg = (st_r.rx_fmt == e1_ldm_pkg::RX_SLICED)
                           ? st_r.sync2[S_RXN] : 1'b0;
        end
        else
        begin
            st_nxt.rx_clk  = st_r.sync2[S_RXC];
            st_nxt.rxd_out = st_r.sync2[S_RXP];
            st_nxt.rxd_pos = st_r.sync2[S_RXP];
            st_nxt.rxd_neg = st_r.sync2[S_RXN];
        end
    end

    //--------------------------------------------------------------
    // State register
    //--------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_r          <= '0;
            st_r.mask0    <= 2'(`LDM_MASK_RST);
            st_r.mask2    <= `LDM_MASK_RST;
            st_r.last_pol <= 2'h3;
        end
        else if (i_ce)
        begin
            st_r <= st_nxt;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign o_rdata               = st_r.rdata;
    assign o_amplitude_threshold = st_r.thr;
    assign o_tx_line_pos         = st_r.txl_pos;
    assign o_tx_line_neg         = st_r.txl_neg;
    assign o_rx_data_out         = st_r.rxd_out;
    assign o_rx_data_pos         = st_r.rxd_pos;
    assign o_rx_data_neg         = st_r.rxd_neg;
    assign o_rx_clock_out        = st_r.rx_clk;
    assign o_free_run_e1_clock   = st_r.e1_clk;
    assign o_serial_frame_marker = st_r.marker;
    assign o_serial_absence_out  = st_r.ser;
    // serial pins released while clock off
    assign o_serial_frame_marker_oe_n = ~st_r.e1_on;
    assign o_serial_absence_out_oe_n  = ~st_r.e1_on;
    assign o_line_absence_state  = st_r.absent[0];
    assign o_sys_absence_state   = st_r.absent[1];
    assign o_int_n = ~(|(st_r.flag0 & ~st_r.mask0) |
                       |(st_r.flag2 & ~st_r.mask2));

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    // unmasked flag drives interrupt
    int_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st_r.flag2[2] && !st_r.mask2[2]) |-> !o_int_n)
        else $error("unmasked flag without interrupt");
    rx_viol_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && evt_v[0]) |=> st_r.flag2[2])
        else $error("receive violation not flagged");
    // zero run flagged at the limit
    rx_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && evt_z[0] && !st_r.hdb3) |->
        st_r.zcnt[0] == `LDM_AMI_ZERO_LIM ##1 st_r.flag2[0])
        else $error("zero run flag wrong");
    // no transmit violation in single rail
    tx_single_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        tx_single |-> !evt_v[1])
        else $error("transmit violation in single rail");
    ins_done_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && st_r.ins && tick[1] && mark[1] && !tx_single && !i_wr)
        |=> !st_r.ins && o_tx_line_neg == $past(st_r.txo_pol))
        else $error("violation not inserted");
    ser_hiz_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !st_r.e1_on |-> o_serial_frame_marker_oe_n &&
        o_serial_absence_out_oe_n)
        else $error("serial pins driven while off");
    loss_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && st_r.absent[0] && !i_alt_active &&
         st_r.rx_fmt != e1_ldm_pkg::RX_SLICED) |=> !o_rx_data_pos &&
        !o_rx_data_neg && !o_rx_data_out)
        else $error("receive data not low in absence");
    sys_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && tx_single) |=> !st_r.absent[1])
        else $error("system absence in single rail");
    line_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(st_r.absent[0]) |-> st_r.flag0[0])
        else $error("line absence not flagged");
    marker_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && ref_tick && st_r.marker) |=> !o_serial_frame_marker)
        else $error("marker longer than one slot");

endmodule : e1_line_defect_monitor

`default_nettype wire

// ==== bench/rx_front_end.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Line front end model
// ----------------------------------------
module rx_front_end (
    // Clock
    input  wire logic i_clk,
    // Line side
    output logic      o_lclk,
    output logic      o_pos,
    output logic      o_neg,
    output logic      o_below
);
    // Idle line, clock stopped between bits
    initial {o_lclk, o_pos, o_neg, o_below} = 4'h0;
    task automatic send_bit(input logic [1:0] s, input logic low);
        @(posedge i_clk);
        o_pos   <= s[0];
        o_neg   <= s[1];
        o_below <= low;
        repeat (4) @(posedge i_clk);
        o_lclk <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_lclk <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : send_bit
endmodule : rx_front_end
`default_nettype wire

// ==== bench/e1_line_defect_monitor_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "e1_ldm_params.svh"
module e1_line_defect_monitor_tb_top;
    logic i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, ref2m = 0;
    logic [3:0]  i_addr = 4'h0;
    logic [7:0]  i_wdata = 8'h00, d;
    logic [21:1] other = '0;
    logic [15:0] lfsr = 16'h91D2;
    logic        lc, lp, ln, lb, int_n, los, soe_n, alt = 0;
    logic        txp, txn, rdo, rck, e1c, mk, so, sabs;
    logic [2:0]  thr;
    logic [1:0]  s, lastp;
    int          failures = 0, checked = 0;
    // Clocks: system 50 MHz, reference 2.048 MHz
    initial forever #10 i_clk = ~i_clk;
    initial forever #244 ref2m = ~ref2m;
    rx_front_end fe (.i_clk(i_clk), .o_lclk(lc), .o_pos(lp), .o_neg(ln),
        .o_below(lb));
    e1_line_defect_monitor dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(d), .i_rx_clk(lc), .i_rx_pos(lp),
        .i_rx_neg(ln), .i_amp_below(lb), .i_amp_above(~lb),
        .o_amplitude_threshold(thr), .i_tx_clk(lc), .i_tx_pos(lp | ln),
        .i_tx_neg(ln), .o_tx_line_pos(txp), .o_tx_line_neg(txn),
        .i_ref_clock_2m(ref2m), .i_other_line_absence(other),
        .i_alt_active(alt), .i_alt_data_pos(1'b0),
        .i_alt_data_neg(1'b0), .i_alt_clock(1'b0), .o_rx_data_out(rdo),
        .o_rx_data_pos(), .o_rx_data_neg(), .o_rx_clock_out(rck),
        .o_free_run_e1_clock(e1c), .o_serial_frame_marker(mk),
        .o_serial_frame_marker_oe_n(), .o_serial_absence_out(so),
        .o_serial_absence_out_oe_n(soe_n), .o_line_absence_state(los),
        .o_sys_absence_state(sabs), .o_int_n(int_n));
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nxt
    task automatic chk(input string n, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
    endtask : rd
    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // Watchdog
    initial
    begin
        #400000;
        failures++;
        give_verdict;
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(`LDM_CFG_ADDR); chk("cfg", d, 8'h00);
        rd(4'hF); chk("unmapped", d, 8'h00);
        chk("oe_off", {7'h0, soe_n}, 8'h01);
        lastp = 2'b10;
        repeat (6)
        begin
            lfsr = nxt(lfsr);
            other <= {lfsr[4:0], lfsr};
            s = lfsr[0] ? 2'b01 : 2'b10;
            lastp = s;
            fe.send_bit(s, 1'b0);
        end
        fe.send_bit(lastp, 1'b0);
        repeat (16) fe.send_bit(2'b00, 1'b0);
        rd(`LDM_FLAG2_ADDR); chk("flag2", d, 8'h1C);
        chk("int", {7'h0, int_n}, 8'h00);
        wr(`LDM_MASK2_ADDR, 8'hFF);
        #1 chk("masked", {7'h0, int_n}, 8'h01);
        wr(`LDM_MASK2_ADDR, 8'h00);
        wr(`LDM_FLAG2_ADDR, 8'hFF);
        rd(`LDM_FLAG2_ADDR); chk("w1c", d, 8'h00);
        // Threshold select reaches the front end
        wr(`LDM_LOS_ADDR, 8'h50);
        #1 chk("thr", {5'h0, thr}, 8'h05);
        repeat (31) fe.send_bit(2'b00, 1'b1);
        chk("los31", {7'h0, los}, 8'h00);
        fe.send_bit(2'b00, 1'b1);
        chk("los32", {7'h0, los}, 8'h01);
        // Clock held high, data low, then alternate source wins
        chk("hold", {6'h0, rck, rdo}, 8'h02);
        @(posedge i_clk) alt <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1 chk("alt", {6'h0, rck, rdo}, 8'h00);
        @(posedge i_clk) alt <= 1'b0;
        rd(`LDM_FLAG0_ADDR); chk("flag0", d, 8'h01);
        // Clock on, transmit dual rail NRZ
        wr(`LDM_CFG_ADDR, 8'h28);
        repeat (60) @(posedge i_clk);
        chk("oe_on", {7'h0, soe_n}, 8'h00);
        // Serial stream: own slot first, then the other channels
        @(posedge mk);
        #1 chk("slot0", {6'h0, mk, so}, 8'h03);
        for (int k = 1; k < 22; k++)
        begin
            @(posedge e1c);
            #1 chk("slot", {6'h0, mk, so}, {7'h0, other[k]});
        end
        // Inserted violation keeps the previous output polarity
        wr(`LDM_ERR_ADDR, 8'h40);
        fe.send_bit(2'b10, 1'b0);
        chk("ins", {6'h0, txp, txn}, 8'h02);
        rd(`LDM_ERR_ADDR); chk("ins_clr", d, 8'h00);
        rd(`LDM_FLAG2_ADDR);
        chk("txviol", d, {2'h0, 1'b1, lastp[1], 4'h0});
        // System absence after N zero intervals in dual rail
        repeat (32) fe.send_bit(2'b00, 1'b1);
        chk("sys", {7'h0, sabs}, 8'h01);
        rd(`LDM_FLAG0_ADDR); chk("flag0s", d, 8'h03);
        // Any-change mode flags the clearing of both
        wr(`LDM_FLAG0_ADDR, 8'h03);
        wr(`LDM_EDGE_ADDR, 8'h02);
        repeat (16)
        begin
            fe.send_bit(2'b01, 1'b0);
            fe.send_bit(2'b10, 1'b0);
        end
        chk("clear", {6'h0, sabs, los}, 8'h00);
        rd(`LDM_FLAG0_ADDR); chk("anyedge", d, 8'h03);
        give_verdict;
    end
endmodule : e1_line_defect_monitor_tb_top
`default_nettype wire
